// ---- crlu_pkg.sv ----
// package: constants and types for the control register load unit
package crlu_pkg;
	localparam logic [3:0] OP_HI = 4'h4;
	localparam logic [3:0] OP_LD_REG = 4'hE;
	localparam logic [3:0] OP_LD_MEM = 4'h7;
	localparam logic [7:0] OP_LOOP_STOP = 8'h8E;
	localparam logic [3:0] SEL_STATUS = 4'h0;
	localparam logic [3:0] SEL_GLOBAL = 4'h1;
	localparam logic [3:0] SEL_VECTOR = 4'h2;
	localparam logic [3:0] SEL_SAVED_ST = 4'h3;
	localparam logic [3:0] SEL_SAVED_PC = 4'h4;
	localparam logic [3:0] SEL_WRAP = 4'h5;
	localparam logic [3:0] SEL_BEGIN = 4'h6;
	localparam logic [3:0] SEL_STOP = 4'h7;
	localparam int BANK_SEL_BIT = 29;
	localparam int PRIV_BIT = 30;
	localparam logic [31:0] SAVED_ST_MASK = 32'h7000_03F3;
	localparam logic [31:0] STATUS_MEM_MASK = 32'h0FFF_0FFF;
	localparam logic [31:0] POST_INC = 32'h0000_0004;
	localparam logic [31:0] PC_STEP = 32'h0000_0002;
	localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
	localparam logic [31:0] SLOT_BASE_ADD = 32'h0000_0002;
	localparam logic [31:0] STATUS_RESET = 32'h7000_00F0;
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_ST_REG = 4'h5;
	localparam logic [3:0] CYC_ST_MEM = 4'h7;
	localparam logic [3:0] CYC_ST_REG_DSP = 4'h3;
	localparam logic [3:0] CYC_ST_MEM_DSP = 4'h5;
	localparam logic [3:0] CYC_DSP_REG = 4'h3;
	localparam logic [3:0] CYC_DSP_MEM = 4'h5;
	localparam logic [3:0] CYC_LOOP_STOP = 4'h3;
	typedef enum {CRLU_IDLE, CRLU_READ, CRLU_BUSY} crlu_state_t;
	typedef enum logic [2:0] {EXC_NONE, EXC_ILLEGAL, EXC_SLOT} crlu_exc_t;
endpackage

// ---- crlu_dec_if.sv ----
// interface: decoded instruction fields passed to the executing stage
`timescale 1ns/100ps
interface crlu_dec_if;
	logic hit;
	logic is_mem;
	logic is_bank;
	logic is_loop_stop;
	logic [3:0] sel;
	logic [2:0] bank_idx;
	logic [3:0] src;
	logic [7:0] disp;
	logic privileged;
	logic is_dsp;
	modport dec (output hit, is_mem, is_bank, is_loop_stop, sel, bank_idx, src, disp,
		privileged, is_dsp);
	modport exe (input hit, is_mem, is_bank, is_loop_stop, sel, bank_idx, src, disp,
		privileged, is_dsp);
endinterface

// ---- crlu_decoder.sv ----
// module: combinational decode of the control load instruction group
`timescale 1ns/100ps
module crlu_decoder (
	input wire logic [15:0] insn_i,
	crlu_dec_if.dec dec
);
	import crlu_pkg::*;
	logic form_reg;
	logic form_mem;
	always_comb begin
		form_reg = (insn_i[15:12] == OP_HI) && (insn_i[3:0] == OP_LD_REG);
		form_mem = (insn_i[15:12] == OP_HI) && (insn_i[3:0] == OP_LD_MEM);
		dec.is_loop_stop = (insn_i[15:8] == OP_LOOP_STOP); // RULE13
		dec.is_bank = (form_reg || form_mem) && insn_i[7];
		dec.sel = insn_i[7:4];
		dec.bank_idx = insn_i[6:4];
		dec.src = insn_i[11:8];
		dec.disp = insn_i[7:0];
		dec.is_mem = form_mem;
		// the begin-address load is handled elsewhere
		dec.hit = dec.is_loop_stop || ((form_reg || form_mem) &&
			(insn_i[7] || insn_i[6:4] != SEL_BEGIN[2:0]));
		dec.privileged = !dec.is_loop_stop &&
			!(!insn_i[7] && insn_i[6:4] == SEL_GLOBAL[2:0]); // RULE1 RULE2
		// loop-stop form is extended-core only; its low byte is a displacement, not a selector
		dec.is_dsp = dec.is_loop_stop || (!insn_i[7] &&
			(insn_i[6:4] == SEL_WRAP[2:0] || insn_i[6:4] == SEL_STOP[2:0])); // RULE11 RULE13
	end
endmodule // crlu_decoder

// ---- crlu_top.sv ----
// module: control register load unit, decode and execute
`timescale 1ns/100ps
// How it works
// RULE1 - all control loads except global-base ones need privileged mode, else illegal; the code also lets loop-stop loads run in user mode
// RULE2 - global-base loads from register or memory run fine in user mode
// RULE3 - bank select 1: operands use bank 1, banked operand targets bank 0
// RULE4 - bank select 0: operands use bank 0, banked operand targets bank 1
// RULE5 - status-word load in a delay slot raises illegal slot
// RULE6 - saved-status load is masked with 0x700003F3
// RULE7 - memory status load masks with 0x0FFF0FFF then bumps address by four
// RULE8 - status loads take 5 or 7 cycles, fewer on DSP; test flag from bit 0
// RULE9 - plain control loads copy all 32 bits; register forms take one cycle
// RULE10 - memory forms read longword at source register, then add four to it
// RULE11 - wrap and loop-boundary loads take 3 from register, 5 from memory
// RULE12 - memory banked load fills alternate-bank register 0..7 then adds four
// RULE13 - loop-stop load decodes 8-bit prefix plus displacement, takes 3 cycles
// RULE14 - loop-stop base is the pc four bytes past the instruction
// RULE15 - displacement sign-extended, doubled, added to base
// RULE16 - in a delay slot the base is branch target plus two
// RULE17 - software knows the loop-stop value differs from the true loop end
// RULE18 - pc advances by two after each completed load unless an exception
module crlu_top (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic [15:0] INSN_I,
	input wire logic ISSUE_I,
	input wire logic [31:0] PC_I,
	input wire logic IN_SLOT_I,
	input wire logic [31:0] SLOT_TARGET_I,
	input wire logic DSP_CORE_I,
	input wire logic [31:0] GPR_RDATA_I,
	input wire logic MEM_ACK_I,
	input wire logic [31:0] MEM_RDATA_I,
	output logic [3:0] GPR_RADDR_O,
	output logic GPR_RBANK_O,
	output logic GPR_WE_O,
	output logic [3:0] GPR_WADDR_O,
	output logic GPR_WBANK_O,
	output logic [31:0] GPR_WDATA_O,
	output logic MEM_REQ_O,
	output logic [31:0] MEM_ADDR_O,
	output logic [31:0] STATUS_WORD_O,
	output logic [31:0] GLOBAL_BASE_O,
	output logic [31:0] VECTOR_BASE_O,
	output logic [31:0] SAVED_STATUS_O,
	output logic [31:0] SAVED_PC_O,
	output logic [31:0] WRAP_BOUNDS_O,
	output logic [31:0] LOOP_STOP_ADDR_O,
	output logic [31:0] PC_O,
	output logic PC_WE_O,
	output logic BUSY_O,
	output logic DONE_O,
	output crlu_pkg::crlu_exc_t EXC_O
);
	import crlu_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	crlu_dec_if dif ();
	crlu_decoder u_dec (
		.insn_i(INSN_I),
		.dec(dif)
	);

	crlu_state_t state_q;
	logic [3:0] cnt_q;
	logic is_mem_q;
	logic is_bank_q;
	logic is_loop_q;
	logic [3:0] sel_q;
	logic [2:0] bank_q;
	logic [3:0] src_q;
	logic [31:0] value_q;
	logic [31:0] addr_q;
	logic user_mode;
	logic bank_sel;
	logic start;
	logic illegal;
	logic slot_bad;
	logic [3:0] cycles;
	logic [31:0] loop_base;
	logic [31:0] disp_ext;

	assign user_mode = !STATUS_WORD_O[PRIV_BIT];
	assign bank_sel = STATUS_WORD_O[BANK_SEL_BIT];
	assign start = ISSUE_I && dif.hit && state_q == CRLU_IDLE;
	assign illegal = (dif.privileged && user_mode) || (dif.is_dsp && !DSP_CORE_I); // RULE1 RULE2
	assign slot_bad = IN_SLOT_I && !dif.is_bank && !dif.is_loop_stop && dif.sel == SEL_STATUS; // RULE5

	// ----------------------------------------
	// cycle counts per form
	// ----------------------------------------
	always_comb begin
		cycles = CYC_ONE; // RULE9
		if (dif.is_loop_stop)
			cycles = CYC_LOOP_STOP; // RULE13
		else if (!dif.is_bank && dif.sel == SEL_STATUS) begin
			if (DSP_CORE_I)
				cycles = dif.is_mem ? CYC_ST_MEM_DSP : CYC_ST_REG_DSP; // RULE8
			else
				cycles = dif.is_mem ? CYC_ST_MEM : CYC_ST_REG; // RULE8
		end else if (dif.is_dsp)
			cycles = dif.is_mem ? CYC_DSP_MEM : CYC_DSP_REG; // RULE11
	end

	assign disp_ext = {{23{dif.disp[7]}}, dif.disp, 1'b0}; // RULE15
	// in a slot the pc tracks the branch target, not this instruction
	assign loop_base = IN_SLOT_I ? SLOT_TARGET_I + SLOT_BASE_ADD : PC_I + PC_AHEAD; // RULE14 RULE16

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	logic finish;
	assign finish = (state_q == CRLU_BUSY && cnt_q <= CYC_ONE) ||
		(state_q == CRLU_READ && MEM_ACK_I && cnt_q <= CYC_ONE);

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			state_q <= CRLU_IDLE;
			cnt_q <= 4'h0;
		end else begin
			unique case (state_q)
				CRLU_IDLE: begin
					if (start && !illegal && !slot_bad) begin
						state_q <= dif.is_mem ? CRLU_READ : CRLU_BUSY;
						cnt_q <= cycles;
					end
				end
				CRLU_READ: begin
					if (MEM_ACK_I) begin
						state_q <= (cnt_q <= CYC_ONE) ? CRLU_IDLE : CRLU_BUSY;
						cnt_q <= (cnt_q > CYC_ONE) ? cnt_q - CYC_ONE : cnt_q;
					end else if (cnt_q > CYC_ONE + CYC_ONE) begin
						cnt_q <= cnt_q - CYC_ONE;
					end
				end
				CRLU_BUSY: begin
					if (cnt_q <= CYC_ONE)
						state_q <= CRLU_IDLE;
					else
						cnt_q <= cnt_q - CYC_ONE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// operand capture and register-file read
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			is_mem_q <= 1'b0;
			is_bank_q <= 1'b0;
			is_loop_q <= 1'b0;
			sel_q <= 4'h0;
			bank_q <= 3'h0;
			src_q <= 4'h0;
			value_q <= 32'h0000_0000;
			addr_q <= 32'h0000_0000;
			GPR_RADDR_O <= 4'h0;
			GPR_RBANK_O <= 1'b0;
		end else begin
			GPR_RADDR_O <= dif.src;
			GPR_RBANK_O <= bank_sel; // RULE3 RULE4
			if (start) begin
				is_mem_q <= dif.is_mem;
				is_bank_q <= dif.is_bank;
				is_loop_q <= dif.is_loop_stop;
				sel_q <= dif.sel;
				bank_q <= dif.bank_idx;
				src_q <= dif.src;
				addr_q <= PC_I;
				value_q <= loop_base + disp_ext; // RULE14 RULE15 RULE16
			end
		end
	end

	// ----------------------------------------
	// memory read: longword at source register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			MEM_REQ_O <= 1'b0;
			MEM_ADDR_O <= 32'h0000_0000;
		end else if (state_q == CRLU_IDLE && start && !illegal && !slot_bad && dif.is_mem) begin
			MEM_REQ_O <= 1'b1;
			MEM_ADDR_O <= GPR_RDATA_I; // RULE10
		end else if (MEM_ACK_I) begin
			MEM_REQ_O <= 1'b0;
		end
	end

	// source data: register data sampled at issue, memory data at the ack
	logic [31:0] src_val;
	logic [31:0] src_hold_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I)
			src_hold_q <= 32'h0000_0000;
		else if (start)
			src_hold_q <= GPR_RDATA_I; // RULE9
		else if (state_q == CRLU_READ && MEM_ACK_I)
			src_hold_q <= MEM_RDATA_I; // RULE10
	end
	assign src_val = src_hold_q;

	// ----------------------------------------
	// control register writes at completion
	// ----------------------------------------
	logic commit;
	logic commit_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I)
			commit_q <= 1'b0;
		else
			commit_q <= finish;
	end
	assign commit = commit_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			STATUS_WORD_O <= STATUS_RESET;
			GLOBAL_BASE_O <= 32'h0000_0000;
			VECTOR_BASE_O <= 32'h0000_0000;
			SAVED_STATUS_O <= 32'h0000_0000;
			SAVED_PC_O <= 32'h0000_0000;
			WRAP_BOUNDS_O <= 32'h0000_0000;
			LOOP_STOP_ADDR_O <= 32'h0000_0000;
		end else if (commit && is_loop_q) begin
			LOOP_STOP_ADDR_O <= value_q; // RULE13
		end else if (commit && !is_bank_q) begin
			unique case (sel_q)
				SEL_STATUS: begin
					// test flag lands in bit 0 straight from the operand
					if (is_mem_q)
						STATUS_WORD_O <= src_val & STATUS_MEM_MASK; // RULE7 RULE8
					else
						STATUS_WORD_O <= src_val; // RULE8
				end
				SEL_GLOBAL: GLOBAL_BASE_O <= src_val; // RULE9
				SEL_VECTOR: VECTOR_BASE_O <= src_val; // RULE9
				SEL_SAVED_ST: SAVED_STATUS_O <= src_val & SAVED_ST_MASK; // RULE6
				SEL_SAVED_PC: SAVED_PC_O <= src_val; // RULE9
				SEL_WRAP: WRAP_BOUNDS_O <= src_val; // RULE11
				SEL_STOP: LOOP_STOP_ADDR_O <= src_val; // RULE11
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// register-file writes: banked target and post-increment
	// ----------------------------------------
	logic inc_pend_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			GPR_WE_O <= 1'b0;
			GPR_WADDR_O <= 4'h0;
			GPR_WBANK_O <= 1'b0;
			GPR_WDATA_O <= 32'h0000_0000;
			inc_pend_q <= 1'b0;
		end else begin
			GPR_WE_O <= 1'b0;
			if (commit && is_bank_q) begin
				GPR_WE_O <= 1'b1;
				GPR_WADDR_O <= {1'b0, bank_q}; // RULE12
				GPR_WBANK_O <= !bank_sel; // RULE3 RULE4
				GPR_WDATA_O <= src_val; // RULE9
				inc_pend_q <= is_mem_q;
			end else if ((commit && is_mem_q) || inc_pend_q) begin
				GPR_WE_O <= 1'b1;
				GPR_WADDR_O <= src_q;
				GPR_WBANK_O <= bank_sel;
				GPR_WDATA_O <= MEM_ADDR_O + POST_INC; // RULE10 RULE12
				inc_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pc, status and exceptions
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			PC_O <= 32'h0000_0000;
			PC_WE_O <= 1'b0;
			DONE_O <= 1'b0;
			EXC_O <= EXC_NONE;
			BUSY_O <= 1'b0;
		end else begin
			PC_WE_O <= commit;
			DONE_O <= commit;
			PC_O <= addr_q + PC_STEP; // RULE18
			BUSY_O <= (state_q != CRLU_IDLE) || (start && !illegal && !slot_bad);
			if (start && slot_bad)
				EXC_O <= EXC_SLOT; // RULE5
			else if (start && illegal)
				EXC_O <= EXC_ILLEGAL; // RULE1
			else
				EXC_O <= EXC_NONE;
		end
	end
endmodule // crlu_top

// ---- crlu_properties.sv ----
// checker: timing and value relations at the control load unit ports
`timescale 1ns/100ps
module crlu_properties
	import crlu_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic [15:0] INSN_I,
	input wire logic ISSUE_I,
	input wire logic [31:0] PC_I,
	input wire logic IN_SLOT_I,
	input wire logic [31:0] SLOT_TARGET_I,
	input wire logic DSP_CORE_I,
	input wire logic [31:0] GPR_RDATA_I,
	input wire logic MEM_REQ_O,
	input wire logic [31:0] MEM_ADDR_O,
	input wire logic [31:0] STATUS_WORD_O,
	input wire logic [31:0] SAVED_STATUS_O,
	input wire logic [31:0] LOOP_STOP_ADDR_O,
	input wire logic [31:0] PC_O,
	input wire logic PC_WE_O,
	input wire logic BUSY_O,
	input wire logic DONE_O,
	input crlu_pkg::crlu_exc_t EXC_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire acc = ISSUE_I && !BUSY_O;
	wire ld4 = acc && INSN_I[15:12] == OP_HI;
	wire priv = STATUS_WORD_O[PRIV_BIT];
	logic [31:0] pc_q, src_q, stop_q;
	// ----------------------------------------
	// capture of the accepted request
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (acc) begin
			pc_q <= PC_I;
			src_q <= GPR_RDATA_I;
			stop_q <= (IN_SLOT_I ? SLOT_TARGET_I + SLOT_BASE_ADD : PC_I + PC_AHEAD)
				+ {{23{INSN_I[7]}}, INSN_I[7:0], 1'b0};
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_user;
		ld4 && INSN_I[7:0] == 8'h2E && !priv && !IN_SLOT_I |-> ##[1:2] EXC_O == EXC_ILLEGAL;
	endproperty
	a_user: assert property (p_user) else $error("user vector load not refused");
	property p_glob;
		ld4 && INSN_I[7:0] == 8'h1E |-> ##3 DONE_O;
	endproperty
	a_glob: assert property (p_glob) else $error("global load late");
	property p_slot;
		ld4 && INSN_I[7:4] == SEL_STATUS && (INSN_I[3:0] == OP_LD_REG
			|| INSN_I[3:0] == OP_LD_MEM) && IN_SLOT_I && priv |-> ##[1:2] EXC_O == EXC_SLOT;
	endproperty
	a_slot: assert property (p_slot) else $error("status load in slot accepted");
	property p_stat;
		ld4 && INSN_I[7:0] == 8'h0E && !IN_SLOT_I && priv && !DSP_CORE_I
			|-> ##1 !DONE_O [*6] ##1 DONE_O;
	endproperty
	a_stat: assert property (p_stat) else $error("status load timing wrong");
	property p_stop;
		acc && INSN_I[15:8] == OP_LOOP_STOP && DSP_CORE_I && priv
			|-> ##5 DONE_O && LOOP_STOP_ADDR_O == stop_q;
	endproperty
	a_stop: assert property (p_stop) else $error("loop stop wrong");
	property p_pc;
		PC_WE_O |-> PC_O == pc_q + PC_STEP;
	endproperty
	a_pc: assert property (p_pc) else $error("pc step wrong");
	property p_exc;
		EXC_O != EXC_NONE |-> !PC_WE_O && $stable(STATUS_WORD_O);
	endproperty
	a_exc: assert property (p_exc) else $error("refused load wrote state");
	property p_addr;
		$rose(MEM_REQ_O) |-> MEM_ADDR_O == src_q;
	endproperty
	a_addr: assert property (p_addr) else $error("read address not source");
	property p_mask;
		(SAVED_STATUS_O & ~SAVED_ST_MASK) == 32'h0000_0000;
	endproperty
	a_mask: assert property (p_mask) else $error("saved status bit outside mask");
	c_slot: cover property (EXC_O == EXC_SLOT);
	c_ill: cover property (EXC_O == EXC_ILLEGAL);
	c_mem: cover property ($rose(MEM_REQ_O));
endmodule // crlu_properties
bind crlu_top crlu_properties chk_u (.*);

// ---- control_register_load_unit_test.sv ----
// testbench: directed load sequences against the control load unit
`timescale 1ns/100ps
module control_register_load_unit_test;
	import crlu_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, iss = 1'b0, slot = 1'b0, dsp = 1'b0, ack = 1'b0, got;
	logic [15:0] insn = 16'h0000;
	logic [31:0] pc = 32'h0000_1000, tgt = 32'h0000_3000, rd = 32'h0000_0000;
	logic [31:0] md = 32'h0000_0000, n, ma, pcv, gwd, ma_o, so, gb, vb, ss, sp, wr, ls, po;
	logic [3:0] gra, gwa, ra;
	logic grb, gwe, gwb, mreq, pwe, busy, done, rb, bz, we;
	logic [31:0] wa [2], wk [2], wv [2];
	crlu_exc_t exc, ex;
	int failures = 0, cmp_count = 0, nw, cyc = 0;
	crlu_top dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n), .INSN_I(insn), .ISSUE_I(iss),
		.PC_I(pc), .IN_SLOT_I(slot), .SLOT_TARGET_I(tgt), .DSP_CORE_I(dsp),
		.GPR_RDATA_I(rd), .MEM_ACK_I(ack), .MEM_RDATA_I(md), .GPR_RADDR_O(gra),
		.GPR_RBANK_O(grb), .GPR_WE_O(gwe), .GPR_WADDR_O(gwa), .GPR_WBANK_O(gwb),
		.GPR_WDATA_O(gwd), .MEM_REQ_O(mreq), .MEM_ADDR_O(ma_o), .STATUS_WORD_O(so),
		.GLOBAL_BASE_O(gb), .VECTOR_BASE_O(vb), .SAVED_STATUS_O(ss), .SAVED_PC_O(sp),
		.WRAP_BOUNDS_O(wr), .LOOP_STOP_ADDR_O(ls), .PC_O(po), .PC_WE_O(pwe),
		.BUSY_O(busy), .DONE_O(done), .EXC_O(exc));
	initial begin
		forever #20 clk = ~clk;
	end
	// hang guard: the whole sequence needs well under two hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		begin
			cmp_count++;
			if (g !== e) begin
				failures++;
				$display("ERROR t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task cap;
		begin
			if (gwe === 1'b1 && nw < 2) begin
				wa[nw] = {28'h000_0000, gwa};
				wk[nw] = {31'h0000_0000, gwb};
				wv[nw] = gwd;
				nw++;
			end
		end
	endtask
	// one instruction, memory answered at once; n = edges after the taking edge
	// up to the one that raises done (0 for a refusal)
	task run(input logic [15:0] i, input logic [31:0] r, input logic [31:0] m, input logic s);
		begin
			@(negedge clk);
			insn = i;
			rd = r;
			md = m;
			slot = s;
			iss = 1'b1;
			n = 32'h0000_0000;
			nw = 0;
			got = 1'b0;
			for (int k = 1; k < 31; k++) begin
				@(negedge clk);
				iss = 1'b0;
				ack = mreq && !got;
				got = got | ack;
				if (ack) ma = ma_o;
				cap;
				if (k == 1) begin
					ra = gra;
					rb = grb;
					bz = busy;
				end
				if (done === 1'b1 || exc !== EXC_NONE) begin
					n = 32'(k - 1);
					ex = exc;
					we = pwe;
					pcv = po;
					break;
				end
			end
			@(negedge clk);
			ack = 1'b0;
			cap;
		end
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(so, STATUS_RESET);
		chk(gb, 32'h0000_0000);
		$display("test reset done");
		run(16'h431E, 32'hDEAD_BEEF, 32'h0000_0000, 1'b0);
		chk(gb, 32'hDEAD_BEEF);
		chk(n, 32'h0000_0002);
		chk(pcv, 32'h0000_1002);
		chk({31'h0000_0000, we}, 32'h0000_0001);
		chk({31'h0000_0000, bz}, 32'h0000_0001);
		run(16'h432E, 32'h8765_4321, 32'h0000_0000, 1'b0);
		chk(vb, 32'h8765_4321);
		run(16'h434E, 32'hA5A5_5A5A, 32'h0000_0000, 1'b0);
		chk(sp, 32'hA5A5_5A5A);
		run(16'h433E, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		chk(ss, 32'h7000_03F3);
		run(16'h435E, 32'h0000_0001, 32'h0000_0000, 1'b0);
		chk(32'(ex), 32'h0000_0001);
		chk(wr, 32'h0000_0000);
		run(16'h8E01, 32'h0000_0000, 32'h0000_0000, 1'b0);
		chk(32'(ex), 32'h0000_0001);
		$display("test plain loads done");
		run(16'h430E, 32'h7000_0301, 32'h0000_0000, 1'b0);
		chk(so, 32'h7000_0301);
		chk(n, 32'h0000_0006);
		dsp = 1'b1;
		run(16'h430E, 32'h7000_0300, 32'h0000_0000, 1'b0);
		chk(n, 32'h0000_0004);
		chk(so, 32'h7000_0300);
		run(16'h430E, 32'h7000_0001, 32'h0000_0000, 1'b1);
		chk(32'(ex), 32'h0000_0002);
		chk(so, 32'h7000_0300);
		run(16'h4307, 32'h0000_2000, 32'h7000_0001, 1'b1);
		chk(32'(ex), 32'h0000_0002);
		$display("test status loads done");
		run(16'h43AE, 32'h1234_5678, 32'h0000_0000, 1'b0);
		chk(wa[0], 32'h0000_0002);
		chk(wk[0], 32'h0000_0000);
		chk(wv[0], 32'h1234_5678);
		chk({31'h0000_0000, rb}, 32'h0000_0001);
		run(16'h43A7, 32'h0000_2000, 32'hCAFE_0001, 1'b0);
		chk(ma, 32'h0000_2000);
		chk({28'h000_0000, ra}, 32'h0000_0003);
		chk(wk[0], 32'h0000_0000);
		chk(wv[0], 32'hCAFE_0001);
		chk(wa[1], 32'h0000_0003);
		chk(wv[1], 32'h0000_2004);
		run(16'h430E, 32'h4000_0000, 32'h0000_0000, 1'b0);
		run(16'h43AE, 32'h0BAD_F00D, 32'h0000_0000, 1'b0);
		chk(wk[0], 32'h0000_0001);
		chk({31'h0000_0000, rb}, 32'h0000_0000);
		$display("test banked loads done");
		run(16'h435E, 32'h0123_4567, 32'h0000_0000, 1'b0);
		chk(wr, 32'h0123_4567);
		chk(n, 32'h0000_0004);
		run(16'h4357, 32'h0000_2400, 32'h7654_3210, 1'b0);
		chk(wr, 32'h7654_3210);
		run(16'h8E80, 32'h0000_0000, 32'h0000_0000, 1'b0);
		chk(ls, 32'h0000_0F04);
		chk(n, 32'h0000_0004);
		run(16'h8E7F, 32'h0000_0000, 32'h0000_0000, 1'b0);
		chk(ls, 32'h0000_1102);
		run(16'h8E01, 32'h0000_0000, 32'h0000_0000, 1'b1);
		chk(ls, 32'h0000_3004);
		$display("test loop stop done");
		// cleared privilege leaves user mode until the next reset
		run(16'h4307, 32'h0000_4000, 32'hFFFF_FFFF, 1'b0);
		chk(so, 32'h0FFF_0FFF);
		chk(wv[0], 32'h0000_4004);
		run(16'h432E, 32'h1111_1111, 32'h0000_0000, 1'b0);
		chk(32'(ex), 32'h0000_0001);
		chk(vb, 32'h8765_4321);
		chk({31'h0000_0000, we}, 32'h0000_0000);
		run(16'h431E, 32'h5555_AAAA, 32'h0000_0000, 1'b0);
		chk(gb, 32'h5555_AAAA);
		run(16'h4317, 32'h0000_5000, 32'h3C3C_C3C3, 1'b0);
		chk(gb, 32'h3C3C_C3C3);
		$display("test user mode done");
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(so, STATUS_RESET);
		chk(gb, 32'h0000_0000);
		$display("test second reset done");
		give_verdict;
	end
endmodule // control_register_load_unit_test
